// ---- hdl/spf_pin_ctrl.v ----
// pin function logic: pause, write protect, shared reset and supply speed-up
`timescale 1ns/10ps
`default_nettype none
`include "spf_defines.vh"
module spf_pin_ctrl #(
	parameter HAS_RESET_PIN = 1,
	parameter [`SPF_WAIT_CNT_W-1:0] VPP_WAIT_CYCLES = `SPF_VPP_WAIT_CYC
) (
	input wire clk,
	input wire rst_n,
	input wire spi_clk,
	input wire cs_n,
	input wire serial_io_0_in,
	input wire serial_io_2_in,
	input wire serial_io_3_in,
	input wire vpp_high,
	input wire quad_io_protocol,
	input wire op_io2_data,
	input wire op_io3_data,
	input wire dtr_op_seen,
	input wire [`SPF_CFG_W-1:0] nonvolatile_config_reg,
	input wire volatile_enhanced_config_reg_wr_en,
	input wire [`SPF_CFG_W-1:0] volatile_enhanced_config_reg_wdata,
	input wire reset_func_dis,
	input wire [`SPF_BP_W-1:0] block_protect_bits,
	input wire out_phase,
	input wire quad_out,
	input wire [7:0] tx_data,
	input wire [3:0] quad_out_data,
	input wire last_data_in,
	input wire vpp_op_eligible,
	input wire op_done,
	output reg [`SPF_CFG_W-1:0] volatile_enhanced_config_reg,
	output reg hold_active_ff,
	output reg [7:0] rx_byte_ff,
	output reg rx_valid_ff,
	output reg [`SPF_BIT_CNT_W-1:0] bit_pos_ff,
	output reg serial_io_0_out,
	output reg serial_io_0_oe_n,
	output reg serial_io_1_out,
	output reg serial_io_1_oe_n,
	output reg serial_io_2_out,
	output reg serial_io_2_oe_n,
	output reg serial_io_3_out,
	output reg serial_io_3_oe_n,
	output reg wp_lock_ff,
	output reg [`SPF_BP_W-1:0] locked_bp_ff,
	output reg hw_reset_req_ff,
	output reg vpp_io_mode_ff,
	output reg start_fast_ff,
	output reg start_std_ff
);
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_WAIT = 3'b010;
	localparam [2:0] ST_RUN = 3'b100;

	wire [4:0] pins_s;
	wire s_sclk;
	wire s_cs_n;
	wire s_io0;
	wire s_io2;
	wire s_io3;
	wire s_vpp;
	reg sclk_d_ff;
	reg dtr_lat_ff;
	reg [7:0] tx_sh_ff;
	reg [2:0] vstate_ff;
	reg [`SPF_WAIT_CNT_W-1:0] wait_cnt_ff;
	wire sel;
	wire rise;
	wire fall;
	wire hold_dis;
	wire hold_now;
	wire io2_data;
	wire io3_data;
	wire run;
	wire vpp_en;

	// all pin inputs cross into clk through two flops
	spf_sync #(
		.WIDTH(5)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din({spi_clk, cs_n, serial_io_0_in, serial_io_2_in,
			serial_io_3_in}),
		.dout(pins_s)
	);
	assign s_sclk = pins_s[4];
	assign s_cs_n = pins_s[3];
	assign s_io0 = pins_s[2];
	assign s_io2 = pins_s[1];
	assign s_io3 = pins_s[0];

	// supply detect is a separate level, synced on its own
	spf_sync #(
		.WIDTH(1)
	) u_sync_vpp (
		.clk(clk),
		.rst_n(rst_n),
		.din(vpp_high),
		.dout(s_vpp)
	);

	assign sel = ~s_cs_n;
	assign rise = s_sclk & ~sclk_d_ff;
	assign fall = ~s_sclk & sclk_d_ff;
	assign io2_data = quad_io_protocol | op_io2_data;
	assign io3_data = quad_io_protocol | op_io3_data;
	assign hold_dis = io3_data | dtr_lat_ff | dtr_op_seen |
		(nonvolatile_config_reg[`SPF_HOLD_DIS_BIT] == `SPF_HOLD_DIS_VAL) |
		(volatile_enhanced_config_reg[`SPF_HOLD_DIS_BIT] ==
		`SPF_HOLD_DIS_VAL);
	// pause only counts while selected
	assign hold_now = sel & ~s_io3 & ~hold_dis;
	assign run = sel & ~hold_now;
	assign vpp_en = volatile_enhanced_config_reg[`SPF_VPP_EN_BIT] ==
		`SPF_VPP_EN_VAL;

	// enhanced configuration register, held here
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			volatile_enhanced_config_reg <= `SPF_VOLATILE_ENHANCED_CONFIG_REG_RST;
		end else if (volatile_enhanced_config_reg_wr_en) begin
			volatile_enhanced_config_reg <= volatile_enhanced_config_reg_wdata;
		end
	end

	// pause state, dtr latch and pin sharing outputs
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// matches the synchroniser reset so no false rise follows reset
			sclk_d_ff <= 1'b1;
			dtr_lat_ff <= 1'b0;
			hold_active_ff <= 1'b0;
			wp_lock_ff <= 1'b0;
			locked_bp_ff <= {`SPF_BP_W{1'b0}};
			hw_reset_req_ff <= 1'b0;
		end else begin
			sclk_d_ff <= s_sclk;
			// dtr disables pause until the end of the command
			if (!sel) begin
				dtr_lat_ff <= 1'b0;
			end else if (dtr_op_seen) begin
				dtr_lat_ff <= 1'b1;
			end
			hold_active_ff <= hold_now;
			wp_lock_ff <= ~io2_data & ~s_io2;
			locked_bp_ff <= (~io2_data & ~s_io2) ?
				block_protect_bits : {`SPF_BP_W{1'b0}};
			hw_reset_req_ff <= (HAS_RESET_PIN != 0) & ~sel & ~s_io3 &
				~reset_func_dis;
		end
	end

	// serial shifting; a pause freezes the counters so resume is exact
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_byte_ff <= 8'h00;
			rx_valid_ff <= 1'b0;
			bit_pos_ff <= {`SPF_BIT_CNT_W{1'b0}};
			tx_sh_ff <= 8'h00;
			serial_io_0_out <= 1'b0;
			serial_io_1_out <= 1'b0;
			serial_io_2_out <= 1'b0;
			serial_io_3_out <= 1'b0;
		end else begin
			rx_valid_ff <= 1'b0;
			if (!sel) begin
				bit_pos_ff <= {`SPF_BIT_CNT_W{1'b0}};
			end else if (run && rise) begin
				rx_byte_ff <= {rx_byte_ff[6:0], s_io0};
				bit_pos_ff <= bit_pos_ff + 1'b1;
				rx_valid_ff <= &bit_pos_ff;
			end
			if (run && fall) begin
				if (quad_out) begin
					serial_io_0_out <= quad_out_data[0];
					serial_io_1_out <= quad_out_data[1];
					serial_io_2_out <= quad_out_data[2];
					serial_io_3_out <= quad_out_data[3];
				end else if (bit_pos_ff == {`SPF_BIT_CNT_W{1'b0}}) begin
					serial_io_1_out <= tx_data[7];
					tx_sh_ff <= {tx_data[6:0], 1'b0};
				end else begin
					serial_io_1_out <= tx_sh_ff[7];
					tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
				end
			end
		end
	end

	// output enables are low while driving; all released when paused
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_io_0_oe_n <= 1'b1;
			serial_io_1_oe_n <= 1'b1;
			serial_io_2_oe_n <= 1'b1;
			serial_io_3_oe_n <= 1'b1;
		end else begin
			serial_io_0_oe_n <= ~(run & out_phase & quad_out);
			serial_io_1_oe_n <= ~(run & out_phase);
			serial_io_2_oe_n <= ~(run & out_phase & quad_out &
				io2_data);
			serial_io_3_oe_n <= ~(run & out_phase & quad_out &
				io3_data);
		end
	end

	// supply speed-up window; host is expected to raise supply in time
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vstate_ff <= ST_IDLE;
			wait_cnt_ff <= {`SPF_WAIT_CNT_W{1'b0}};
			vpp_io_mode_ff <= 1'b0;
			start_fast_ff <= 1'b0;
			start_std_ff <= 1'b0;
		end else begin
			start_fast_ff <= 1'b0;
			start_std_ff <= 1'b0;
			case (vstate_ff)
			ST_IDLE: begin
				if (last_data_in && vpp_op_eligible && vpp_en) begin
					vstate_ff <= ST_WAIT;
					wait_cnt_ff <= {`SPF_WAIT_CNT_W{1'b0}};
					vpp_io_mode_ff <= 1'b1;
				end else if (last_data_in) begin
					vstate_ff <= ST_RUN;
					start_std_ff <= 1'b1;
				end
			end
			ST_WAIT: begin
				if (s_vpp) begin
					vstate_ff <= ST_RUN;
					start_fast_ff <= 1'b1;
				end else if (wait_cnt_ff == VPP_WAIT_CYCLES - 1'b1) begin
					vstate_ff <= ST_RUN;
					start_std_ff <= 1'b1;
				end else begin
					wait_cnt_ff <= wait_cnt_ff + 1'b1;
				end
			end
			ST_RUN: begin
				// pin stays an I/O until the operation ends
				if (op_done) begin
					vstate_ff <= ST_IDLE;
					vpp_io_mode_ff <= 1'b0;
				end
			end
			default: begin
				vstate_ff <= ST_IDLE;
				vpp_io_mode_ff <= 1'b0;
			end
			endcase
		end
	end
endmodule // spf_pin_ctrl
`default_nettype wire

// ---- hdl/spf_defines.vh ----
// constants for the flash hold, write-protect and supply pin sharing logic
// Notes on behaviour
// - While pause is active and selected, the device ignores data and clock and keeps its place.
// - While paused, every data line the device could drive is released.
// - In the quad protocol the pause pin is data line 3 and pause is off while selected.
// - The pause pin is a two-way data line during the four quad read and program operations.
// - Pause is off when bit 4 of either configuration register selects disabling.
// - Pause is off as soon as a double-transfer-rate operation is recognised.
// - While deselected, the shared pin low requests a hardware reset unless disabled.
// - In single or dual protocol a low protect pin locks the area set by the block protect bits.
// - The protect pin is data line 2 in quad fast reads and in the quad protocol.
// - The supply speed-up is allowed only with enhanced bit 3 at 0, the pin then being an I/O.
// - Enhanced bit 3 resets to 1, so the speed-up is off by default.
// - Without the raised supply within 200 ms the operation starts at standard speed.
// - Input bits are taken on rising serial clock edges, output bits shifted on falling edges.
`ifndef SPF_DEFINES_VH
`define SPF_DEFINES_VH
`define SPF_CFG_W 8
`define SPF_HOLD_DIS_BIT 4
`define SPF_HOLD_DIS_VAL 1'b0
`define SPF_VPP_EN_BIT 3
`define SPF_VPP_EN_VAL 1'b0
`define SPF_VOLATILE_ENHANCED_CONFIG_REG_RST 8'hFF
`define SPF_BP_W 4
`define SPF_BIT_CNT_W 3
`define SPF_VPP_WAIT_MS 200
`define SPF_CLK_KHZ 40000
`define SPF_WAIT_CNT_W 23
// 200 ms at 40 MHz, sized to the wait counter
`define SPF_VPP_WAIT_CYC 23'h7A1200
`endif

// ---- hdl/spf_sync.v ----
// two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module spf_sync #(
	parameter WIDTH = 1
) (
	input wire clk,
	input wire rst_n,
	input wire [WIDTH-1:0] din,
	output reg [WIDTH-1:0] dout
);
	reg [WIDTH-1:0] meta_ff;
	// reset value is all ones: idle level of select and the active-low pins
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= {WIDTH{1'b1}};
			dout <= {WIDTH{1'b1}};
		end else begin
			meta_ff <= din;
			dout <= meta_ff;
		end
	end
endmodule // spf_sync
`default_nettype wire

// ---- sim/spf_host_model.sv ----
// host side serial model
`timescale 1ns/10ps
`default_nettype none
module spf_host_model (
	output logic spi_clk,
	output logic cs_n,
	output logic serial_io_0_in,
	output logic serial_io_3_in
);
	initial begin
		spi_clk = 1'h0;
		cs_n = 1'h1;
		serial_io_0_in = 1'h0;
		serial_io_3_in = 1'h1;
	end
	// a released line flips, so a stale value never passes for data
	task automatic sel(input logic v);
		cs_n = v;
		if (v) serial_io_0_in = ~serial_io_0_in;
		#200;
	endtask
	// clock stands low outside frames
	task automatic xfer(input logic [7:0] b, input int nb);
		for (int i = 7; i > 7 - nb; i--) begin
			serial_io_0_in = b[i];
			#100 spi_clk = 1'h1;
			#100 spi_clk = 1'h0;
		end
	endtask
	task automatic hold(input logic v);
		serial_io_3_in = v;
		#300;
	endtask
endmodule // spf_host_model
`default_nettype wire

// ---- sim/spf_pin_ctrl_sva.sv ----
// assertions on the pin sharing block ports
`timescale 1ns/10ps
`default_nettype none
module spf_pin_ctrl_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic quad_io_protocol,
	input wire logic dtr_op_seen,
	input wire logic [7:0] nonvolatile_config_reg,
	input wire logic [7:0] volatile_enhanced_config_reg,
	input wire logic hold_active_ff,
	input wire logic [2:0] bit_pos_ff,
	input wire logic serial_io_1_oe_n,
	input wire logic hw_reset_req_ff,
	input wire logic vpp_io_mode_ff,
	input wire logic start_fast_ff,
	input wire logic start_std_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_hiz;
		hold_active_ff && $past(hold_active_ff) |-> serial_io_1_oe_n;
	endproperty
	a_hiz: assert property (p_hiz) else $error("output on in pause");
	property p_keep;
		hold_active_ff && $past(hold_active_ff) |-> $stable(bit_pos_ff);
	endproperty
	a_keep: assert property (p_keep) else $error("bit moved in pause");
	property p_quad; quad_io_protocol |=> !hold_active_ff; endproperty
	a_quad: assert property (p_quad) else $error("pause in quad");
	property p_cfg;
		!nonvolatile_config_reg[4] || !volatile_enhanced_config_reg[4] |=>
			!hold_active_ff;
	endproperty
	a_cfg: assert property (p_cfg) else $error("pause not off");
	property p_dtr; dtr_op_seen |=> !hold_active_ff; endproperty
	a_dtr: assert property (p_dtr) else $error("pause in dtr");
	property p_vrst;
		$rose(rst_n) |-> volatile_enhanced_config_reg == 8'hFF;
	endproperty
	a_vrst: assert property (p_vrst) else $error("bad reset value");
	property p_ven;
		$rose(vpp_io_mode_ff) |-> !$past(volatile_enhanced_config_reg[3]);
	endproperty
	a_ven: assert property (p_ven) else $error("supply not enabled");
	property p_std; $rose(vpp_io_mode_ff) |-> !start_std_ff [*8]; endproperty
	a_std: assert property (p_std) else $error("early slow start");
	c_hold: cover property (hold_active_ff);
	c_fast: cover property (start_fast_ff);
	c_rst: cover property (hw_reset_req_ff);
endmodule // spf_pin_ctrl_sva
bind spf_pin_ctrl spf_pin_ctrl_sva u_sva (.*);
`default_nettype wire

// ---- sim/spf_pin_ctrl_tb.sv ----
// self-checking bench for the pin sharing block
`timescale 1ns/10ps
`default_nettype none
module spf_pin_ctrl_tb;
	localparam int W = 50;
	logic clk = 0, rst_n, spi_clk, cs_n, serial_io_0_in, serial_io_3_in;
	logic serial_io_2_in, vpp_high, quad_io_protocol, op_io2_data;
	logic op_io3_data, dtr_op_seen, volatile_enhanced_config_reg_wr_en, reset_func_dis, out_phase;
	logic quad_out, last_data_in, vpp_op_eligible, op_done, hold_active_ff;
	logic rx_valid_ff;
	logic [7:0] nonvolatile_config_reg, volatile_enhanced_config_reg_wdata, tx_data, rx_byte_ff;
	logic [3:0] block_protect_bits, quad_out_data, locked_bp_ff;
	logic [7:0] volatile_enhanced_config_reg;
	logic [3:0] q_out, q_oe_n;
	logic [2:0] bit_pos_ff;
	logic wp_lock_ff, hw_reset_req_ff, vpp_io_mode_ff, start_fast_ff;
	logic start_std_ff, serial_io_0_out, serial_io_1_out, serial_io_2_out;
	logic serial_io_3_out, serial_io_0_oe_n, serial_io_1_oe_n;
	logic serial_io_2_oe_n, serial_io_3_oe_n;
	int miscompares = 0, checks_done = 0, cyc = 0, n, nv = 0;
	spf_pin_ctrl #(.VPP_WAIT_CYCLES(23'(W))) DUT (.*);
	assign q_out = {serial_io_3_out, serial_io_2_out, serial_io_1_out,
		serial_io_0_out};
	assign q_oe_n = {serial_io_3_oe_n, serial_io_2_oe_n, serial_io_1_oe_n,
		serial_io_0_oe_n};
	spf_host_model host (.*);
	always #12.5 clk = ~clk;
	task wt(input int c);
		repeat (c) @(posedge clk);
		#2;
	endtask
	task chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task t_rx;
		host.sel(0);
		host.xfer(8'hA5, 8);
		wt(5);
		chk("rx", 8'hA5, rx_byte_ff);
		chk("valid", 8'h1, nv);
		host.sel(1);
		wt(5);
		chk("pos", 8'h0, bit_pos_ff);
	endtask
	// output byte after a command byte, then one quad nibble
	task t_tx;
		tx_data = 8'hC3;
		host.sel(0);
		host.xfer(8'h0B, 8);
		wt(5);
		tx_data = 8'h00;
		chk("tx", 8'h1, serial_io_1_out);
		for (int k = 6; k >= 0; k--) begin
			host.xfer(8'h00, 1);
			wt(5);
			chk("tx", (8'hC3 >> k) & 8'h01, serial_io_1_out);
		end
		{quad_out, out_phase, op_io2_data, op_io3_data} = 4'hF;
		quad_out_data = 4'hA;
		host.xfer(8'h00, 1);
		wt(5);
		chk("quad", 8'h0A, q_out);
		chk("qoe", 8'h00, q_oe_n);
		{quad_out, out_phase, op_io2_data, op_io3_data} = 4'h0;
		host.sel(1);
	endtask
	// pause mid-byte with output on, stray clocks, then resume
	task t_hold;
		host.sel(0);
		out_phase = 1;
		host.xfer(8'h3C, 3);
		wt(5);
		chk("oe", 8'h0, serial_io_1_oe_n);
		host.hold(0);
		wt(1);
		chk("hold", 8'h1, hold_active_ff);
		chk("oe", 8'h1, serial_io_1_oe_n);
		host.xfer(8'hFF, 2);
		wt(5);
		chk("pos", 8'h3, bit_pos_ff);
		host.hold(1);
		wt(1);
		out_phase = 0;
		host.xfer(8'hE0, 5);
		wt(5);
		chk("rx", 8'h3C, rx_byte_ff);
		host.sel(1);
	endtask
	task wvecr(input logic [7:0] v);
		volatile_enhanced_config_reg_wdata = v;
		volatile_enhanced_config_reg_wr_en = 1;
		wt(1);
		volatile_enhanced_config_reg_wr_en = 0;
		chk("volatile_enhanced_config_reg", v, volatile_enhanced_config_reg);
	endtask
	task t_off;
		for (int i = 0; i < 4; i++) begin
			wt(1);
			quad_io_protocol = (i == 0);
			op_io3_data = (i == 1);
			nonvolatile_config_reg[4] = (i != 2);
			dtr_op_seen = (i == 3);
			host.sel(0);
			host.hold(0);
			wt(1);
			chk("hold", 8'h0, hold_active_ff);
			host.hold(1);
			host.sel(1);
		end
		wt(1);
		{quad_io_protocol, op_io3_data, dtr_op_seen} = 3'h0;
		nonvolatile_config_reg = 8'hFF;
		wvecr(8'hEF);
		host.sel(0);
		host.hold(0);
		wt(1);
		chk("hold", 8'h0, hold_active_ff);
		host.hold(1);
		host.sel(1);
		wvecr(8'hFF);
	endtask
	task t_shared;
		host.hold(0);
		wt(1);
		chk("rst", 8'h1, hw_reset_req_ff);
		chk("hold", 8'h0, hold_active_ff);
		reset_func_dis = 1;
		wt(3);
		chk("rst", 8'h0, hw_reset_req_ff);
		reset_func_dis = 0;
		host.hold(1);
		wt(1);
	endtask
	task t_wp;
		serial_io_2_in = 0;
		wt(6);
		chk("lock", 8'h1, wp_lock_ff);
		chk("bp", 8'h5, locked_bp_ff);
		block_protect_bits = 4'hA;
		wt(2);
		chk("bp", 8'h0A, locked_bp_ff);
		op_io2_data = 1;
		wt(3);
		chk("lock", 8'h0, wp_lock_ff);
		op_io2_data = 0;
		quad_io_protocol = 1;
		wt(3);
		chk("lock", 8'h0, wp_lock_ff);
		quad_io_protocol = 0;
		serial_io_2_in = 1;
		wt(6);
	endtask
	task pulse(input int k);
		if (k) last_data_in = 1;
		else op_done = 1;
		wt(1);
		{last_data_in, op_done} = 2'h0;
	endtask
	task t_vpp;
		chk("volatile_enhanced_config_reg", 8'hFF, volatile_enhanced_config_reg);
		pulse(1);
		chk("std", 8'h1, start_std_ff);
		chk("io", 8'h0, vpp_io_mode_ff);
		pulse(0);
		wvecr(8'hF7);
		vpp_op_eligible = 0;
		pulse(1);
		chk("std", 8'h1, start_std_ff);
		chk("io", 8'h0, vpp_io_mode_ff);
		pulse(0);
		vpp_op_eligible = 1;
		wt(1);
		pulse(1);
		chk("io", 8'h1, vpp_io_mode_ff);
		vpp_high = 1;
		for (n = 0; n < 10 && start_fast_ff !== 1; n++) wt(1);
		chk("fast", 8'h1, n < 10);
		pulse(0);
		wt(1);
		chk("io", 8'h0, vpp_io_mode_ff);
		vpp_high = 0;
		wt(4);
		pulse(1);
		for (n = 0; n < 99 && start_std_ff !== 1; n++) wt(1);
		chk("wait", 8'h1, n == W);
		pulse(0);
	endtask
	// reset after the last operation has ended must bring the enhanced register back to its default
	task t_reset;
		rst_n = 0;
		wt(2);
		rst_n = 1;
		chk("volatile_enhanced_config_reg", 8'hFF, volatile_enhanced_config_reg);
		chk("io", 8'h0, vpp_io_mode_ff);
		wt(4);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (rx_valid_ff === 1'b1) nv++;
		if (cyc > 20000) begin
			miscompares++;
			stop_test;
		end
	end
	initial begin
		{rst_n, vpp_high, quad_io_protocol, op_io2_data, op_io3_data} = 5'h0;
		{dtr_op_seen, volatile_enhanced_config_reg_wr_en, reset_func_dis, out_phase} = 4'h0;
		{quad_out, last_data_in, op_done, quad_out_data} = 7'h00;
		{serial_io_2_in, vpp_op_eligible} = 2'h3;
		{nonvolatile_config_reg, volatile_enhanced_config_reg_wdata, tx_data} = 24'hFFFFA5;
		block_protect_bits = 4'h5;
		repeat (5) @(posedge clk);
		#2 rst_n = 1;
		wt(4);
		t_rx;
		t_tx;
		t_hold;
		t_off;
		t_shared;
		t_wp;
		t_vpp;
		t_reset;
		stop_test;
	end
endmodule // spf_pin_ctrl_tb
`default_nettype wire
